// File: core/ccd_hpattern.sv
// horizontal pixel pattern generator: storage, barrier and reset gate
`default_nettype none
module ccd_hpattern (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic run_i,
  output var  logic pat5_o,
  output var  logic pat6_o,
  output var  logic pat7_o,
  output logic      pix_done_o
);
  logic [1:0] ph_r;
  logic [1:0] ph_nxt;
  logic [1:0] sub_r;
  logic [1:0] sub_nxt;
  // two halves per pixel, each ccd_timing_pkg::PIX_HALF cycles
  always_comb begin
    ph_nxt  = ph_r;
    sub_nxt = sub_r;
    if (!run_i) begin
      ph_nxt  = 2'h0;
      sub_nxt = 2'h0;
    end else if (sub_r == 2'(ccd_timing_pkg::PIX_HALF - 1)) begin
      sub_nxt = 2'h0;
      ph_nxt  = (ph_r == 2'h1) ? 2'h0 : 2'h1;
    end else begin
      sub_nxt = sub_r + 2'h1;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_r   <= 2'h0;
      sub_r  <= 2'h0;
      pat5_o <= 1'b0;
      pat6_o <= 1'b1;
      pat7_o <= 1'b0;
    end else begin
      ph_r   <= ph_nxt;
      sub_r  <= sub_nxt;
      pat5_o <= run_i && (ph_nxt == 2'h1);
      pat6_o <= !(run_i && (ph_nxt == 2'h1));
      // reset gate high in the cycle after each pixel ends, so not during the first pixel of a line
      pat7_o <= run_i && (ph_nxt == 2'h0) && (sub_nxt == 2'h0);
    end
  end
  // one pixel ends in the last cycle of the second half, just before the last-phase clock rises
  assign pix_done_o = run_i && (ph_r == 2'h1) &&
                      (sub_r == 2'(ccd_timing_pkg::PIX_HALF - 1));
endmodule
`default_nettype wire

// File: core/ccd_readout_timing_generator.sv
// readout timing generator driving an interline ccd sensor
`default_nettype none
module ccd_readout_timing_generator (
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       start_i,
  input  wire logic [1:0] mode_i,
  input  wire logic       shutter_en_i,
  input  wire logic       cd_off_i,
  input  wire logic       bias_stable_i,
  output var  logic       busy_o,
  output var  logic       frame_done_o,
  output var  logic [1:0] vert_phase_one_top_o,
  output var  logic       vert_phase_two_top_o,
  output var  logic       vert_phase_three_top_o,
  output var  logic       vert_phase_four_top_o,
  output var  logic [1:0] vert_phase_one_bottom_o,
  output var  logic       vert_phase_two_bottom_o,
  output var  logic       vert_phase_three_bottom_o,
  output var  logic       vert_phase_four_bottom_o,
  output var  logic [3:0] horiz_phase_one_storage_o,
  output var  logic [3:0] horiz_phase_one_barrier_o,
  output var  logic [3:0] horiz_phase_two_storage_o,
  output var  logic [3:0] horiz_phase_two_barrier_o,
  output var  logic [3:0] horiz_last_phase_o,
  output var  logic [3:0] reset_gate_o,
  output var  logic       substrate_shutter_o
);
  localparam int unsigned W = ccd_timing_pkg::CNT_W;
  localparam logic [1:0] V1_LOW  = 2'h0;
  localparam logic [1:0] V1_MID  = 2'h1;
  localparam logic [1:0] V1_HIGH = 2'h2;

  // ----------------------------------------
  // reset release and bias pin synchroniser
  // ----------------------------------------
  logic rst_meta_r;
  logic rst_n;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end
  logic bias_ok;
  ccd_sync2 #(.W(1)) u_bias_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .d_i     (bias_stable_i),
    .q_o     (bias_ok)
  );

  // ----------------------------------------
  // frame sequencer
  // ----------------------------------------
  ccd_timing_pkg::state_type st_r;
  ccd_timing_pkg::state_type st_nxt;
  ccd_timing_pkg::mode_type  mode_r;
  ccd_timing_pkg::mode_type  mode_nxt;
  logic [W-1:0] tmr_r;
  logic [W-1:0] tmr_nxt;
  logic [W-1:0] line_r;
  logic [W-1:0] line_nxt;
  logic [W-1:0] pix_r;
  logic [W-1:0] pix_nxt;
  logic [W-1:0] lcyc_r;
  logic [W-1:0] lcyc_nxt;
  logic [W-1:0] fcyc_r;
  logic [W-1:0] fcyc_nxt;
  logic         pix_done;
  logic         hrun;
  logic         is_long;
  logic [W-1:0] lines_min;
  logic [W-1:0] pix_min;
  logic [W-1:0] line_cyc;
  logic [W-1:0] frame_cyc;

  assign is_long = ccd_timing_pkg::long_mode(mode_r);
  // per-mode minimum counts
  assign lines_min = is_long ? W'(ccd_timing_pkg::LINES_LONG)
                             : W'(ccd_timing_pkg::LINES_SHORT);
  assign pix_min   = (mode_r == ccd_timing_pkg::MODE_SINGLE) ? W'(ccd_timing_pkg::PIX_LONG)
                                                              : W'(ccd_timing_pkg::PIX_SHORT);
  assign line_cyc  = (mode_r == ccd_timing_pkg::MODE_SINGLE)
                     ? W'(ccd_timing_pkg::LINE_SINGLE_CYC)
                     : W'(ccd_timing_pkg::LINE_DUAL_CYC);
  always_comb begin
    case (mode_r)
      ccd_timing_pkg::MODE_QUAD:   frame_cyc = W'(ccd_timing_pkg::FRAME_QUAD_CYC);
      ccd_timing_pkg::MODE_SINGLE: frame_cyc = W'(ccd_timing_pkg::FRAME_SINGLE_CYC);
      default:                     frame_cyc = W'(ccd_timing_pkg::FRAME_DUAL_CYC);
    endcase
  end

  // next state of the sequencer
  always_comb begin
    st_nxt   = st_r;
    mode_nxt = mode_r;
    tmr_nxt  = tmr_r + W'(1);
    line_nxt = line_r;
    pix_nxt  = pix_r;
    lcyc_nxt = lcyc_r + W'(1);
    fcyc_nxt = fcyc_r + W'(1);
    case (st_r)
      ccd_timing_pkg::ST_IDLE: begin
        tmr_nxt  = '0;
        lcyc_nxt = '0;
        fcyc_nxt = '0;
        if (start_i) begin
          mode_nxt = ccd_timing_pkg::mode_type'(mode_i);
          line_nxt = '0;
          st_nxt   = (shutter_en_i && bias_ok) ? ccd_timing_pkg::ST_SH_DLY
                                               : ccd_timing_pkg::ST_PED_LD;
        end
      end
      ccd_timing_pkg::ST_SH_DLY: if (tmr_r == W'(ccd_timing_pkg::HD_CYC - 1)) begin
        tmr_nxt = '0;
        st_nxt  = ccd_timing_pkg::ST_SHUT;
      end
      ccd_timing_pkg::ST_SHUT: if (tmr_r == W'(ccd_timing_pkg::SUB_CYC - 1)) begin
        tmr_nxt = '0;
        st_nxt  = ccd_timing_pkg::ST_SH_END;
      end
      ccd_timing_pkg::ST_SH_END: if (tmr_r == W'(ccd_timing_pkg::HD_CYC - 1)) begin
        tmr_nxt = '0;
        st_nxt  = ccd_timing_pkg::ST_PED_LD;
      end
      ccd_timing_pkg::ST_PED_LD: if (tmr_r == W'(ccd_timing_pkg::PED_CYC - 1)) begin
        tmr_nxt = '0;
        st_nxt  = ccd_timing_pkg::ST_PD;
      end
      ccd_timing_pkg::ST_PD: if (tmr_r == W'(ccd_timing_pkg::PD_CYC - 1)) begin
        tmr_nxt = '0;
        st_nxt  = ccd_timing_pkg::ST_PED_TR;
      end
      ccd_timing_pkg::ST_PED_TR: if (tmr_r == W'(ccd_timing_pkg::PED_CYC - 1)) begin
        tmr_nxt = '0;
        st_nxt  = ccd_timing_pkg::ST_VDLY;
      end
      ccd_timing_pkg::ST_VDLY: if (tmr_r == W'(ccd_timing_pkg::VD_CYC - 1)) begin
        tmr_nxt  = '0;
        lcyc_nxt = '0;
        st_nxt   = ccd_timing_pkg::ST_VSTEP1;
      end
      ccd_timing_pkg::ST_VSTEP1: if (tmr_r == W'(ccd_timing_pkg::V_CYC - 1)) begin
        tmr_nxt = '0;
        st_nxt  = ccd_timing_pkg::ST_VSTEP2;
      end
      ccd_timing_pkg::ST_VSTEP2: if (tmr_r == W'(ccd_timing_pkg::V_CYC - 1)) begin
        tmr_nxt = '0;
        st_nxt  = ccd_timing_pkg::ST_HDLY;
      end
      ccd_timing_pkg::ST_HDLY: if (tmr_r == W'(ccd_timing_pkg::HS_CYC - 1)) begin
        tmr_nxt = '0;
        pix_nxt = '0;
        st_nxt  = ccd_timing_pkg::ST_HPIX;
      end
      ccd_timing_pkg::ST_HPIX: if (pix_done) begin
        pix_nxt = pix_r + W'(1);
        if (pix_r == pix_min - W'(1)) begin
          st_nxt = ccd_timing_pkg::ST_LPAD;
        end
      end
      ccd_timing_pkg::ST_LPAD: if (lcyc_r >= line_cyc - W'(1)) begin
        tmr_nxt  = '0;
        line_nxt = line_r + W'(1);
        if (line_r == lines_min - W'(1)) begin
          st_nxt = ccd_timing_pkg::ST_FPAD;
        end else begin
          st_nxt = ccd_timing_pkg::ST_VDLY;
        end
      end
      ccd_timing_pkg::ST_FPAD: if (fcyc_r >= frame_cyc - W'(1)) begin
        st_nxt = ccd_timing_pkg::ST_IDLE;
      end
      default: st_nxt = ccd_timing_pkg::ST_IDLE;
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_r   <= ccd_timing_pkg::ST_IDLE;
      mode_r <= ccd_timing_pkg::MODE_QUAD;
      tmr_r  <= '0;
      line_r <= '0;
      pix_r  <= '0;
      lcyc_r <= '0;
      fcyc_r <= '0;
    end else begin
      st_r   <= st_nxt;
      mode_r <= mode_nxt;
      tmr_r  <= tmr_nxt;
      line_r <= line_nxt;
      pix_r  <= pix_nxt;
      lcyc_r <= lcyc_nxt;
      fcyc_r <= fcyc_nxt;
    end
  end

  // ----------------------------------------
  // horizontal patterns five to seven
  // ----------------------------------------
  logic pat5;
  logic pat6;
  logic pat7;
  assign hrun = (st_r == ccd_timing_pkg::ST_HPIX);
  ccd_hpattern u_hpat (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n),
    .run_i      (hrun),
    .pat5_o     (pat5),
    .pat6_o     (pat6),
    .pat7_o     (pat7),
    .pix_done_o (pix_done)
  );

  // ----------------------------------------
  // vertical patterns and pin mapping
  // ----------------------------------------
  logic [1:0] pv1;
  logic       p2;
  logic       p3;
  logic       p4;
  logic       cd_off;
  logic [3:0] use_ch;
  // four-phase step: phase one falls in step two, three rises with it
  always_comb begin
    pv1 = V1_LOW;
    p2  = 1'b1;
    p3  = 1'b0;
    p4  = 1'b0;
    case (st_r)
      ccd_timing_pkg::ST_PED_LD, ccd_timing_pkg::ST_PED_TR: pv1 = V1_MID;
      ccd_timing_pkg::ST_PD:     pv1 = V1_HIGH;
      ccd_timing_pkg::ST_VSTEP1: begin
        pv1 = V1_MID;
        p4  = 1'b1;
        p2  = 1'b0;
      end
      ccd_timing_pkg::ST_VSTEP2: begin
        pv1 = V1_LOW;
        p3  = 1'b1;
        p2  = 1'b0;
        p4  = 1'b1;
      end
      default: pv1 = V1_LOW;
    endcase
  end
  // c and d channels used in quad and dual a-c, else optionally off
  assign cd_off = cd_off_i && (mode_r != ccd_timing_pkg::MODE_QUAD) &&
                  (mode_r != ccd_timing_pkg::MODE_DUAL_AC);
  assign use_ch = {!cd_off, !cd_off, 1'b1, 1'b1};
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      vert_phase_one_top_o      <= V1_LOW;
      vert_phase_two_top_o      <= 1'b1;
      vert_phase_three_top_o    <= 1'b0;
      vert_phase_four_top_o     <= 1'b0;
      vert_phase_one_bottom_o   <= V1_LOW;
      vert_phase_two_bottom_o   <= 1'b1;
      vert_phase_three_bottom_o <= 1'b0;
      vert_phase_four_bottom_o  <= 1'b0;
      horiz_phase_one_storage_o <= '0;
      horiz_phase_one_barrier_o <= '0;
      horiz_phase_two_storage_o <= '1;
      horiz_phase_two_barrier_o <= '1;
      horiz_last_phase_o        <= '1;
      reset_gate_o              <= '0;
      substrate_shutter_o       <= 1'b0;
      busy_o                    <= 1'b0;
      frame_done_o              <= 1'b0;
    end else begin
      vert_phase_one_top_o      <= pv1;
      vert_phase_three_top_o    <= p3;
      // long modes swap top phases two and four
      vert_phase_two_top_o      <= is_long ? p4 : p2;
      vert_phase_four_top_o     <= is_long ? p2 : p4;
      vert_phase_one_bottom_o   <= pv1;
      vert_phase_two_bottom_o   <= p2;
      vert_phase_three_bottom_o <= p3;
      vert_phase_four_bottom_o  <= p4;
      // off level held high; a-b rate shared so c/d is a x1 multiple
      horiz_phase_one_storage_o <= (use_ch & {4{pat5}}) | ~use_ch;
      horiz_phase_one_barrier_o <= (use_ch & {4{pat5}}) | ~use_ch;
      horiz_phase_two_storage_o <= (use_ch & {4{pat6}}) | ~use_ch;
      horiz_phase_two_barrier_o <= (use_ch & {4{pat6}}) | ~use_ch;
      horiz_last_phase_o        <= (use_ch & {4{pat6}}) | ~use_ch;
      reset_gate_o              <= (use_ch & {4{pat7}}) | ~use_ch;
      substrate_shutter_o       <= (st_nxt == ccd_timing_pkg::ST_SHUT);
      busy_o                    <= (st_nxt != ccd_timing_pkg::ST_IDLE);
      frame_done_o              <= (st_r == ccd_timing_pkg::ST_FPAD) &&
                                   (st_nxt == ccd_timing_pkg::ST_IDLE);
    end
  end

  // ----------------------------------------
  // assertions and covers
  // ----------------------------------------
  int unsigned sh_len;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) sh_len <= 0;
    else if (substrate_shutter_o) sh_len <= sh_len + 1;
    else sh_len <= 0;
  end
  shut_len_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    $fell(substrate_shutter_o) |-> sh_len >= ccd_timing_pkg::SUB_CYC)
    else $error("shutter width too short");
  shut_bias_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(substrate_shutter_o) |-> $past(bias_ok, 26))
    else $error("shutter pulsed before bias stable");
  pd_width_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(vert_phase_one_bottom_o == V1_HIGH) |->
      (vert_phase_one_bottom_o == V1_HIGH) [*8] ##17 (vert_phase_one_bottom_o == V1_HIGH))
    else $error("photodiode transfer too short");
  lead_ped_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(vert_phase_one_bottom_o == V1_HIGH) |-> $past(vert_phase_one_bottom_o == V1_MID, 100))
    else $error("leading pedestal too short");
  last_phase_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    horiz_last_phase_o == horiz_phase_two_storage_o)
    else $error("last phase differs from storage two");
  swap_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    is_long && st_r == ccd_timing_pkg::ST_VSTEP1 |=> vert_phase_two_top_o == 1'b1)
    else $error("top phase two not remapped");
  mode_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    st_r != ccd_timing_pkg::ST_IDLE |=> $stable(mode_r))
    else $error("mode changed mid frame");
  hdelay_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(hrun) |-> $past(st_r == ccd_timing_pkg::ST_HDLY, 5))
    else $error("horizontal started too early");
  cd_off_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    cd_off |=> horiz_phase_one_storage_o[3:2] == 2'h3 && reset_gate_o[3:2] == 2'h3)
    else $error("unused channel not held off");
  row_fall_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    $fell(vert_phase_one_bottom_o == V1_MID) && vert_phase_one_bottom_o == V1_LOW &&
      vert_phase_four_bottom_o |-> vert_phase_three_bottom_o)
    else $error("phase one fell without phase three high");
  frame_c: cover property (@(posedge clk_i) disable iff (!rst_n) frame_done_o);
  shut_c:  cover property (@(posedge clk_i) disable iff (!rst_n) $fell(substrate_shutter_o));
  pix_c:   cover property (@(posedge clk_i) disable iff (!rst_n) pix_done && is_long);
endmodule
`default_nettype wire

// File: core/ccd_sync2.sv
// two flip-flop synchroniser for asynchronous levels
`default_nettype none
module ccd_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  // first stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule
`default_nettype wire

// File: core/ccd_timing_pkg.sv
// constants and types shared by the ccd timing generator
`default_nettype none
package ccd_timing_pkg;
  localparam int unsigned CLK_HZ        = 25000000;
  localparam int unsigned CLK_PERIOD_PS = 40000;
  // times in picoseconds, figures as printed
  localparam int unsigned T_PD_PS      = 1000000;  // photodiode transfer 1.0 us
  localparam int unsigned T_PED_PS     = 4000000;  // pedestal 4.0 us
  localparam int unsigned T_VD_PS      = 1000000;  // line transfer delay 1.0 us
  localparam int unsigned T_V_PS       = 2000000;  // vertical step 2.0 us
  localparam int unsigned T_HS_PS      = 200000;   // horizontal delay 0.2 us
  localparam int unsigned T_E_PS       = 25000;    // pixel period 25.0 ns
  localparam int unsigned T_SUB_PS     = 1000000;  // shutter width 1.0 us
  localparam int unsigned T_HD_PS      = 1000000;  // shutter delay 1.0 us
  localparam int unsigned T_RST_PS     = 2500;     // reset gate width 2.5 ns
  localparam int unsigned LINE_DUAL_NS   = 45500;
  localparam int unsigned LINE_SINGLE_NS = 87600;
  localparam int unsigned FRAME_QUAD_US   = 57400;
  localparam int unsigned FRAME_DUAL_US   = 114800;
  localparam int unsigned FRAME_SINGLE_US = 220700;
  // least times round up
  function automatic int unsigned cyc_up(input int unsigned ps);
    cyc_up = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    if (cyc_up < 1) cyc_up = 1;
  endfunction
  localparam int unsigned PD_CYC   = cyc_up(T_PD_PS);
  localparam int unsigned PED_CYC  = cyc_up(T_PED_PS);
  localparam int unsigned VD_CYC   = cyc_up(T_VD_PS);
  localparam int unsigned V_CYC    = cyc_up(T_V_PS);
  localparam int unsigned HS_CYC   = cyc_up(T_HS_PS);
  localparam int unsigned E_CYC    = cyc_up(T_E_PS);
  localparam int unsigned SUB_CYC  = cyc_up(T_SUB_PS);
  localparam int unsigned HD_CYC   = cyc_up(T_HD_PS);
  localparam int unsigned RST_CYC  = cyc_up(T_RST_PS);
  // pixel period: two cycles per half, at least one reset cycle
  localparam int unsigned PIX_HALF = 2;
  localparam int unsigned LINE_DUAL_CYC   = (LINE_DUAL_NS * 1000 + CLK_PERIOD_PS - 1)
                                            / CLK_PERIOD_PS;
  localparam int unsigned LINE_SINGLE_CYC = (LINE_SINGLE_NS * 1000 + CLK_PERIOD_PS - 1)
                                            / CLK_PERIOD_PS;
  localparam int unsigned FRAME_QUAD_CYC   = FRAME_QUAD_US * (CLK_HZ / 1000000);
  localparam int unsigned FRAME_DUAL_CYC   = FRAME_DUAL_US * (CLK_HZ / 1000000);
  localparam int unsigned FRAME_SINGLE_CYC = FRAME_SINGLE_US * (CLK_HZ / 1000000);
  localparam int unsigned LINES_SHORT = 1260;
  localparam int unsigned LINES_LONG  = 2520;
  localparam int unsigned LAST_SHORT  = 632;
  localparam int unsigned LAST_LONG   = 1264;
  localparam int unsigned PIX_SHORT   = 853;
  localparam int unsigned PIX_LONG    = 1706;
  localparam int unsigned CNT_W = 24;
  typedef enum logic [1:0] {
    MODE_QUAD = 2'h0, MODE_DUAL_AB = 2'h1, MODE_DUAL_AC = 2'h2, MODE_SINGLE = 2'h3
  } mode_type;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0, ST_SH_DLY = 4'h1, ST_SHUT = 4'h3, ST_SH_END = 4'h2,
    ST_PED_LD = 4'h6, ST_PD     = 4'h7, ST_PED_TR = 4'h5, ST_VDLY  = 4'h4,
    ST_VSTEP1 = 4'hc, ST_VSTEP2 = 4'hd, ST_HDLY   = 4'hf, ST_HPIX  = 4'he,
    ST_LPAD   = 4'ha, ST_FPAD   = 4'hb
  } state_type;
  function automatic logic long_mode(input mode_type m);
    long_mode = (m == MODE_DUAL_AB) || (m == MODE_SINGLE);
  endfunction
endpackage
`default_nettype wire

// File: tb/ccd_readout_timing_generator_bench.sv
// self-checking bench for the ccd readout timing generator
`default_nettype none
module ccd_readout_timing_generator_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TC = 40;
  logic        clk_i, arst_n_i, start_i, shutter_en_i, cd_off_i, bias_stable_i;
  logic        busy_o, frame_done_o, substrate_shutter_o, busy_q;
  logic [1:0]  mode_i, vert_phase_one_top_o, vert_phase_one_bottom_o;
  logic        vert_phase_two_top_o, vert_phase_three_top_o, vert_phase_four_top_o;
  logic        vert_phase_two_bottom_o, vert_phase_three_bottom_o, vert_phase_four_bottom_o;
  logic [3:0]  horiz_phase_one_storage_o, horiz_phase_one_barrier_o, horiz_phase_two_storage_o;
  logic [3:0]  horiz_phase_two_barrier_o, horiz_last_phase_o, reset_gate_o;
  logic [31:0] rows, row_pix, row_per, sub_cnt, sub_w, integ, pd_w, ped_w, pix_per, rg_w;
  logic [4:0]  top_v, bot_v, swp_v;
  int          bad_count, tests_run, map_err;
  ccd_readout_timing_generator dut (.clk_i, .arst_n_i, .start_i, .mode_i, .shutter_en_i,
    .cd_off_i, .bias_stable_i, .busy_o, .frame_done_o, .vert_phase_one_top_o,
    .vert_phase_two_top_o, .vert_phase_three_top_o, .vert_phase_four_top_o,
    .vert_phase_one_bottom_o, .vert_phase_two_bottom_o, .vert_phase_three_bottom_o,
    .vert_phase_four_bottom_o, .horiz_phase_one_storage_o, .horiz_phase_one_barrier_o,
    .horiz_phase_two_storage_o, .horiz_phase_two_barrier_o, .horiz_last_phase_o,
    .reset_gate_o, .substrate_shutter_o);
  ccd_sensor_model model (.clk_i, .rst_n_i(arst_n_i), .v1_i(vert_phase_one_bottom_o),
    .sub_i(substrate_shutter_o), .hl_i(horiz_last_phase_o[0]), .rg_i(reset_gate_o[0]),
    .rows_o(rows), .row_pix_o(row_pix), .row_per_o(row_per), .sub_cnt_o(sub_cnt),
    .sub_w_o(sub_w), .integ_o(integ), .pd_w_o(pd_w), .ped_w_o(ped_w),
    .pix_per_o(pix_per), .rg_w_o(rg_w));
  // clock
  initial begin
    clk_i = 1'b0;
    forever #(TC / 2) clk_i = ~clk_i;
  end
  // vertical phases as top and bottom words
  assign top_v = {vert_phase_one_top_o, vert_phase_two_top_o, vert_phase_three_top_o,
                  vert_phase_four_top_o};
  assign bot_v = {vert_phase_one_bottom_o, vert_phase_two_bottom_o,
                  vert_phase_three_bottom_o, vert_phase_four_bottom_o};
  assign swp_v = {vert_phase_one_bottom_o, vert_phase_four_bottom_o,
                  vert_phase_three_bottom_o, vert_phase_two_bottom_o};
  // per-cycle watch of pin mapping, last phase and c/d clocks
  // mapping judged from the second busy cycle: the first still shows the idle mode
  always @(posedge clk_i) begin
    busy_q <= busy_o;
    if (arst_n_i && frame_done_o !== 1'b0) map_err++;
    if (arst_n_i && busy_o === 1'b1 && busy_q === 1'b1) begin
      if (top_v !== (mode_i[0] ? swp_v : bot_v)) map_err++;
      if (horiz_last_phase_o !== horiz_phase_two_storage_o) map_err++;
      if ({horiz_phase_one_barrier_o[0], horiz_phase_two_barrier_o[0]} !==
          {horiz_phase_one_storage_o[0], horiz_phase_two_storage_o[0]}) map_err++;
      if (mode_i[0] && cd_off_i) begin
        if ({reset_gate_o[3:2], horiz_phase_one_storage_o[3:2]} !== 4'hf) map_err++;
      end else if (horiz_phase_one_storage_o[2] !== horiz_phase_one_storage_o[0]) begin
        map_err++;
      end
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // reset, start one frame and run until three rows have moved
  task automatic run(input logic [1:0] m, input logic sh, input logic bs, input logic cd);
    int n;
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    {mode_i, shutter_en_i, bias_stable_i, cd_off_i} <= {m, sh, bs, cd};
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    start_i <= 1'b1;
    map_err = 0;
    @(posedge clk_i);
    start_i <= 1'b0;
    repeat (2) @(negedge clk_i);
    check(busy_o, 1);
    n = 0;
    while (rows < 3 && n < 9000) begin
      @(posedge clk_i);
      n++;
    end
    @(negedge clk_i);
    check(n < 9000, 1);
    check(map_err, 0);
  endtask
  task automatic t_reset;
    repeat (20) @(negedge clk_i);
    check(vert_phase_one_top_o, 0);
    check(vert_phase_two_top_o, 1);
    check(horiz_phase_two_storage_o, 4'hf);
    check({horiz_phase_one_storage_o, reset_gate_o, substrate_shutter_o, busy_o}, 0);
    $display("reset test done");
  endtask
  task automatic t_quad;
    run(2'h0, 1'b1, 1'b1, 1'b0);
    check(sub_cnt, 1);
    check(sub_w, 1000 / TC);
    // phase one pins lag the shutter pin by one cycle
    check(integ, 6000 / TC + 1);
    check(pd_w, 1000 / TC);
    check(ped_w, 4000 / TC);
    check(row_pix, 853);
    check(pix_per, 4);
    check(rg_w, 1);
    check(row_per >= (45500 + TC - 1) / TC, 1);
    $display("quad test done");
  endtask
  task automatic t_single;
    run(2'h3, 1'b1, 1'b0, 1'b1);
    check(sub_cnt, 0);
    check(row_pix, 1706);
    check(row_per >= (87600 + TC - 1) / TC, 1);
    $display("single test done");
  endtask
  task automatic t_dual_ab;
    run(2'h1, 1'b0, 1'b1, 1'b0);
    check(sub_cnt, 0);
    check(row_pix, 853);
    check(pix_per, 4);
    $display("dual ab test done");
  endtask
  task automatic t_dual_ac;
    run(2'h2, 1'b1, 1'b1, 1'b0);
    @(posedge clk_i);
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    repeat (300) @(negedge clk_i);
    check(sub_cnt, 1);
    check(busy_o, 1);
    check(row_pix, 853);
    $display("dual ac test done");
  endtask
  // watchdog
  initial begin
    repeat (40000) @(posedge clk_i);
    bad_count++;
    $display("Error at %0t: run timed out", $time);
    wrap_up;
  end
  // main sequence
  initial begin
    {arst_n_i, start_i, mode_i, shutter_en_i, cd_off_i, bias_stable_i} = '0;
    {bad_count, tests_run, map_err} = '0;
    t_reset;
    t_quad;
    t_single;
    t_dual_ab;
    t_dual_ac;
    wrap_up;
  end
endmodule
`default_nettype wire

// File: tb/ccd_sensor_model.sv
// sensor-side model: measures rows, pixels and shutter timing from the pins
`default_nettype none
module ccd_sensor_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [1:0]  v1_i,
  input  wire logic        sub_i,
  input  wire logic        hl_i,
  input  wire logic        rg_i,
  output var  logic [31:0] rows_o,
  output var  logic [31:0] row_pix_o,
  output var  logic [31:0] row_per_o,
  output var  logic [31:0] sub_cnt_o,
  output var  logic [31:0] sub_w_o,
  output var  logic [31:0] integ_o,
  output var  logic [31:0] pd_w_o,
  output var  logic [31:0] ped_w_o,
  output var  logic [31:0] pix_per_o,
  output var  logic [31:0] rg_w_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] t, t_sr, t_sf, t_hi, t_mid, t_row, t_hl, t_rg, pix;
  logic [1:0]  v1_q;
  logic        sub_q, hl_q, rg_q;
  // edge detection and interval timing at the sensor pins
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {t, t_sr, t_sf, t_hi, t_mid, t_row, t_hl, t_rg, pix} <= '0;
      {rows_o, row_pix_o, row_per_o, sub_cnt_o, sub_w_o} <= '0;
      {integ_o, pd_w_o, ped_w_o, pix_per_o, rg_w_o} <= '0;
      {v1_q, sub_q, rg_q} <= '0;
      hl_q <= 1'b1;
    end else begin
      t <= t + 1;
      {v1_q, sub_q, hl_q, rg_q} <= {v1_i, sub_i, hl_i, rg_i};
      if (sub_i && !sub_q) t_sr <= t;
      // shutter fall empties the photodiodes and starts integration
      if (!sub_i && sub_q) begin
        sub_cnt_o <= sub_cnt_o + 1;
        sub_w_o   <= t - t_sr;
        t_sf      <= t;
      end
      if (v1_i == 2'h1 && v1_q != 2'h1) t_mid <= t;
      if (v1_i == 2'h2 && v1_q != 2'h2) begin
        ped_w_o <= t - t_mid;
        t_hi    <= t;
      end
      // charge leaves the photodiodes as phase one falls from high
      if (v1_q == 2'h2 && v1_i == 2'h1) begin
        pd_w_o  <= t - t_hi;
        integ_o <= t - t_sf;
      end
      // one pixel charge to the output at each last phase fall
      if (!hl_i && hl_q) begin
        pix       <= pix + 1;
        pix_per_o <= t - t_hl;
        t_hl      <= t;
      end
      if (rg_i && !rg_q) t_rg <= t;
      if (!rg_i && rg_q) rg_w_o <= t - t_rg;
      // a row enters the horizontal register at phase one fall
      if (v1_q == 2'h1 && v1_i == 2'h0) begin
        rows_o    <= rows_o + 1;
        row_pix_o <= pix;
        pix       <= '0;
        row_per_o <= t - t_row;
        t_row     <= t;
      end
    end
  end
endmodule
`default_nettype wire
